// [rtl/asrsc_ctrl.sv]
// Readout, ready strobe, synchronisation and power-down control of a
// 24-bit converter, with results queued through a FIFO.
// Assumes sclk is synchronous to mclk and the filter supplies results.
module asrsc_ctrl
	import asrsc_pkg::*;
#(
	parameter int BITS  = RESULT_BITS,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic            mclk,
	input  wire logic            reset,
	input  wire logic            sclk,
	input  wire logic [BITS-1:0] result_data,
	input  wire logic            result_valid,
	output logic                 result_ready,
	output logic                 ready_and_serial_out_pin,
	output logic                 mod_clk_en,
	output logic                 mod_reset,
	output logic                 power_down,
	output logic                 data_valid
);
	//////////////////////////////////////////////////////////////////////
	asrsc_phase_e     phase;
	asrsc_phase_e     next_phase;
	logic [9:0]       cnt;
	logic [9:0]       next_cnt;
	logic [BITS-1:0]  result_shift_register;
	logic [BITS-1:0]  next_shift;
	logic [4:0]       ptr;
	logic [4:0]       next_ptr;
	logic             pin;
	logic             next_pin;
	logic             sclk_d;
	logic [4:0]       hi_cycles;
	logic [4:0]       next_hi_cycles;
	logic [2:0]       strobes;
	logic [2:0]       next_strobes;
	logic             pdown;
	logic             next_pdown;
	logic [2:0]       div;
	logic [2:0]       next_div;
	logic [BITS-1:0]  fifo_data;
	logic             fifo_valid;
	logic             fifo_take;
	logic             cycle_end;
	logic             sclk_fall;
	logic             sclk_rise;
	logic             dropped;
	logic             next_dropped;
	logic             cold_start;

	function automatic logic [9:0] cnt10(input int v);
		return 10'(v - 1);
	endfunction

	asrsc_fifo #(.WIDTH(BITS), .DEPTH(DEPTH)) u_fifo (
		.mclk      (mclk),
		.reset     (reset),
		.in_data   (result_data),
		.in_valid  (result_valid),
		.in_ready  (result_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_take)
	);

	assign sclk_fall = sclk_d && !sclk;
	assign sclk_rise = !sclk_d && sclk;
	// The closing high interval runs on through the load, so the pin stays high
	// for 24 clocks before the low strobe and the cycle sums to 384 clocks.
	assign cycle_end  = phase == ASRSC_CLOSE && cnt == cnt10(CLOSE_CLKS - LOAD_CLKS);
	// The load takes the next result; an empty FIFO repeats the old one.
	assign fifo_take  = cycle_end && fifo_valid;
	// A power-down leaves the hold counter at its end value until the restart.
	assign cold_start = hi_cycles == 5'(PDOWN_CYCLES);

	//////////////////////////////////////////////////////////////////////
	// Phase sequencer and pin driver.
	always_comb
	begin
		next_phase     = phase;
		next_cnt       = cnt + 10'h001;
		next_shift     = result_shift_register;
		next_ptr       = ptr;
		next_pin       = pin;
		next_hi_cycles = hi_cycles;
		next_strobes   = strobes;
		next_pdown     = pdown;
		// Only a cycle in which every sample of sclk was high counts toward a sync.
		next_dropped   = cycle_end ? !sclk : (dropped || !sclk);
		case (phase)
			ASRSC_LOAD:
			begin
				next_ptr = 5'h00;
				next_pin = 1'b1;
				if (cnt == cnt10(LOAD_CLKS))
				begin
					next_phase = ASRSC_LOW;
					next_cnt   = '0;
					next_pin   = 1'b0;
					if (strobes != 3'(VALID_STROBE))
						next_strobes = strobes + 3'h1;
				end
			end
			ASRSC_LOW:
				if (cnt == cnt10(LOW_CLKS))
				begin
					next_phase = ASRSC_HIGH;
					next_cnt   = '0;
					next_pin   = 1'b1;
				end
			ASRSC_HIGH:
				if (cnt == cnt10(HIGH_CLKS))
				begin
					next_phase = ASRSC_SHIFT;
					next_cnt   = '0;
					next_pin   = result_shift_register[BITS-1];
				end
			ASRSC_SHIFT:
			begin
				if (sclk_fall && ptr != 5'(BITS))
				begin
					next_ptr = ptr + 5'h01;
					next_pin = (ptr == 5'(BITS - 1)) ? 1'b0
						: result_shift_register[5'(BITS - 2) - ptr];
				end
				else if (sclk_fall)
					next_pin = 1'b0;
				if (cnt == cnt10(SHIFT_CLKS))
				begin
					next_phase = ASRSC_CLOSE;
					next_cnt   = '0;
					next_pin   = 1'b1;
					next_ptr   = 5'h00;
				end
			end
			ASRSC_CLOSE:
				if (cycle_end)
				begin
					next_phase = ASRSC_LOAD;
					next_cnt   = '0;
					if (fifo_valid)
						next_shift = fifo_data;
					next_hi_cycles = (sclk && !dropped) ? hi_cycles + 5'h01 : 5'h00;
					if (sclk && !dropped && hi_cycles == 5'(SYNC_CYCLES - 1))
					begin
						next_phase = ASRSC_PULSE;
						next_pin   = 1'b0;
					end
				end
			ASRSC_PULSE:
				if (cnt == cnt10(SYNC_PULSE_CLKS))
				begin
					next_phase = ASRSC_HOLD;
					next_cnt   = '0;
					next_pin   = 1'b1;
				end
			ASRSC_HOLD:
			begin
				if (cnt == cnt10(CYCLE_CLKS))
				begin
					next_cnt = '0;
					if (hi_cycles != 5'(PDOWN_CYCLES))
						next_hi_cycles = hi_cycles + 5'h01;
					if (hi_cycles == 5'(PDOWN_CYCLES - 1))
						next_pdown = 1'b1;
				end
				if (!sclk)
				begin
					next_phase   = ASRSC_START;
					next_cnt     = '0;
					next_strobes = 3'h0;
					next_pdown   = 1'b0;
				end
			end
			ASRSC_START:
			begin
				// Restart delay differs after power-down, where the filter restarts cold.
				if (cnt == (cold_start ? cnt10(WAKE_START_CLKS - LOAD_CLKS)
					: cnt10(SYNC_START_CLKS - LOAD_CLKS)))
				begin
					next_phase     = ASRSC_LOAD;
					next_cnt       = '0;
					next_hi_cycles = 5'h00;
				end
			end
			default:
			begin
				next_phase = ASRSC_LOAD;
				next_cnt   = '0;
			end
		endcase
	end

	always_comb
	begin
		next_div = (div == 3'(MOD_DIV - 1)) ? 3'h0 : div + 3'h1;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			phase                 <= ASRSC_LOAD;
			cnt                   <= '0;
			result_shift_register <= '0;
			ptr                   <= '0;
			pin                   <= 1'b1;
			sclk_d                <= 1'b0;
			hi_cycles             <= '0;
			strobes               <= '0;
			pdown                 <= 1'b0;
			div                   <= '0;
			dropped               <= 1'b1;
		end
		else
		begin
			phase                 <= next_phase;
			cnt                   <= next_cnt;
			result_shift_register <= next_shift;
			ptr                   <= next_ptr;
			pin                   <= next_pin;
			sclk_d                <= sclk;
			hi_cycles             <= next_hi_cycles;
			strobes               <= next_strobes;
			pdown                 <= next_pdown;
			div                   <= next_div;
			dropped               <= next_dropped;
		end
	end

	assign ready_and_serial_out_pin = pin;
	// The modulator is held only once the three-clock pulse is over.
	assign mod_reset  = phase == ASRSC_HOLD;
	assign power_down = pdown;
	assign mod_clk_en = div == 3'h0 && !mod_reset;
	assign data_valid = strobes == 3'(VALID_STROBE);

	//////////////////////////////////////////////////////////////////////
	sequence s_low6;
		!pin [*6];
	endsequence

	sequence s_high6;
		pin [*6];
	endsequence

	strobe_shape_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_LOAD && next_phase == ASRSC_LOW) |=> s_low6 ##1 s_high6)
		else $error("ready strobe shape wrong");

	close_high_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_SHIFT && next_phase == ASRSC_CLOSE) |=> pin [*8])
		else $error("closing interval not high");

	// Clocks since the last strobe; disarmed across a restart, whose first
	// period is not a full cycle.
	logic [9:0] gap_cnt;
	logic [9:0] next_gap_cnt;
	logic       gap_armed;
	logic       next_gap_armed;

	always_comb
	begin
		next_gap_cnt   = (gap_cnt == 10'h3FF) ? gap_cnt : gap_cnt + 10'h001;
		next_gap_armed = gap_armed && !mod_reset && phase != ASRSC_START;
		if (phase == ASRSC_LOAD && next_phase == ASRSC_LOW)
		begin
			next_gap_cnt   = 10'h000;
			next_gap_armed = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			gap_cnt   <= 10'h000;
			gap_armed <= 1'b0;
		end
		else
		begin
			gap_cnt   <= next_gap_cnt;
			gap_armed <= next_gap_armed;
		end
	end

	cycle_len_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_LOAD && next_phase == ASRSC_LOW && gap_armed)
		|-> gap_cnt == 10'(CYCLE_CLKS - 1))
		else $error("conversion cycle length wrong");

	rise_hold_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_SHIFT && sclk_rise && next_phase == ASRSC_SHIFT) |=> $stable(pin))
		else $error("pin changed on shift clock rise");

	ptr_reset_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_LOAD) |=> ptr == 0)
		else $error("bit pointer not reset at load");

	msb_first_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_HIGH && next_phase == ASRSC_SHIFT)
		|=> pin == result_shift_register[BITS-1])
		else $error("msb not presented first");

	overread_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_SHIFT && ptr == 5'(BITS) && sclk_fall && next_phase == ASRSC_SHIFT)
		|=> !pin)
		else $error("pin not low after over-read");

	hold_bit_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_SHIFT && !sclk_fall && next_phase == ASRSC_SHIFT) |=> $stable(pin))
		else $error("pin changed without shift clock");

	sync_pulse_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_CLOSE && next_phase == ASRSC_PULSE)
		|=> !pin [*3] ##1 (pin && mod_reset))
		else $error("sync pulse shape wrong");

	release_a: assert property (@(posedge mclk) disable iff (reset)
		(phase == ASRSC_HOLD && !sclk) |=> !mod_reset)
		else $error("modulator not released on shift clock fall");
endmodule

// [rtl/asrsc_pkg.sv]
// Package of constants for the converter readout and sync control block.
// Assumes every CLKS count is in master-clock cycles of mclk; SYNC_CYCLES and PDOWN_CYCLES count conversion cycles.
package asrsc_pkg;
	localparam int RESULT_BITS     = 24;
	localparam int CYCLE_CLKS      = 384;
	localparam int READY_CLKS      = 36;
	localparam int SHIFT_CLKS      = 348;
	localparam int LOAD_CLKS       = 6;
	localparam int LOW_CLKS        = 6;
	localparam int HIGH_CLKS       = 6;
	localparam int CLOSE_CLKS      = 24;
	localparam int SYNC_PULSE_CLKS = 3;
	localparam int SYNC_CYCLES     = 4;
	localparam int PDOWN_CYCLES    = 20;
	localparam int VALID_STROBE    = 6;
	localparam int MOD_DIV         = 6;
	localparam int OSR             = 64;
	localparam int SYNC_START_CLKS = 314;
	localparam int WAKE_START_CLKS = 592;
	localparam int FIFO_DEPTH      = 16;
	localparam logic [8:0] CNT_RESET = 9'h000;
	typedef enum logic [2:0] {ASRSC_LOAD, ASRSC_LOW, ASRSC_HIGH, ASRSC_SHIFT,
		ASRSC_CLOSE, ASRSC_PULSE, ASRSC_HOLD, ASRSC_START} asrsc_phase_e;
endpackage

// [rtl/asrsc_fifo.sv]
// Result FIFO between the conversion source and the readout shifter.
// Assumes a single clock; both sides use valid and ready.
module asrsc_fifo
	import asrsc_pkg::*;
#(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
)(
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      next_wr_ptr;
	logic [AW:0]      next_rd_ptr;
	logic             do_wr;
	logic             do_rd;
	logic [WIDTH-1:0] next_out_data;

	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	always_comb
	begin
		next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
		// A word written into the slot that is read next is passed straight through,
		// because the array shows it only one clock later.
		if (do_wr && next_rd_ptr[AW-1:0] == wr_ptr[AW-1:0])
			next_out_data = in_data;
		else
			next_out_data = mem[next_rd_ptr[AW-1:0]];
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			out_data <= '0;
		end
		else
		begin
			wr_ptr   <= next_wr_ptr;
			rd_ptr   <= next_rd_ptr;
			out_data <= next_out_data;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule

// [dv/asrsc_host_model.sv]
// Host model: drives the shift clock and samples the shared ready/data pin.
// Assumes sclk may change only at falling mclk edges, as the block samples it.
module asrsc_host_model (
	input  wire logic mclk,
	input  wire logic pin,
	output logic      sclk
);
	timeunit 1ns;
	timeprecision 1ns;
	initial sclk = 1'h0;
	// Bits are taken as sclk rises, while the pin is settled from the last fall.
	task automatic shift(input int n, output logic [31:0] got);
		got = '0;
		repeat (n)
		begin
			@(negedge mclk);
			sclk = 1'h1;
			got = {got[30:0], pin};
			repeat (2) @(negedge mclk);
			sclk = 1'h0;
			repeat (2) @(negedge mclk);
		end
	endtask
	task automatic hold(input int clks);
		@(negedge mclk);
		sclk = 1'h1;
		repeat (clks) @(negedge mclk);
	endtask
	task automatic drop();
		@(negedge mclk);
		sclk = 1'h0;
	endtask
endmodule

// [dv/tb_asrsc_ctrl.sv]
// Bench for the converter readout block: strobe timing, serial words,
// result FIFO, synchronisation and power-down, against a host model.
module tb_asrsc_ctrl
	import asrsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'h0;
	logic        reset = 1'h1;
	logic [23:0] result_data = 24'h000000;
	logic        result_valid = 1'h0;
	logic        sclk, result_ready, pin, mod_clk_en, mod_reset, power_down, data_valid;
	int          miscompares, n_checks, hi, nstrobe, n, d;
	time         t_strobe, t1;
	event        strobe_ev;
	logic [23:0] w, nxt, fq [$];
	logic [23:0] corner [2] = '{24'h000000, 24'h7FFFFF};
	always #20 mclk = ~mclk;
	asrsc_ctrl dut (.mclk(mclk), .reset(reset), .sclk(sclk), .result_data(result_data),
		.result_valid(result_valid), .result_ready(result_ready),
		.ready_and_serial_out_pin(pin), .mod_clk_en(mod_clk_en), .mod_reset(mod_reset),
		.power_down(power_down), .data_valid(data_valid));
	asrsc_host_model host (.mclk(mclk), .pin(pin), .sclk(sclk));
	////////////////////////////////////////////////////////////////////////////////
	// A strobe is a fall after a long quiet high; shifting resets the run so
	// a string of one bits is never taken for a strobe.
	always @(negedge mclk)
	begin
		if (pin === 1'h1 && sclk === 1'h0)
			hi++;
		else
		begin
			if (pin === 1'h0 && hi >= 12)
			begin
				nstrobe++;
				t_strobe = $time;
				->strobe_ev;
			end
			hi = 0;
		end
	end
	function automatic logic [31:0] exp_bits(input logic [23:0] v, input int k);
		if (k >= RESULT_BITS)
			return {8'h00, v} << (k - RESULT_BITS);
		return {8'h00, v} >> (RESULT_BITS - k);
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic push(input logic [23:0] v);
		@(negedge mclk);
		result_data = v;
		result_valid = 1'h1;
		@(negedge mclk);
		result_valid = 1'h0;
	endtask
	task automatic read_cycle(input int k, input logic [23:0] v);
		logic [31:0] got;
		@strobe_ev;
		repeat (14) @(negedge mclk);
		host.shift(k, got);
		check("serial bits", exp_bits(v, k), got);
	endtask
	task automatic wake_window(input int exp);
		t1 = $time;
		@strobe_ev;
		d = int'((t_strobe - t1) / 40);
		check("restart delay", 1, d inside {[exp - 8 : exp + 8]});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(53534));
		repeat (10) @(posedge mclk);
		@(negedge mclk);
		reset = 1'h0;
		@strobe_ev;
		t1 = t_strobe;
		n = 0;
		do
		begin
			n++;
			@(negedge mclk);
		end
		while (pin === 1'h0);
		check("ready low width", LOW_CLKS, n);
		w = 24'h800000;
		push(w);
		for (int k = 0; k < 9; k++)
		begin
			nxt = (k < 2) ? corner[k] : 24'($urandom);
			n = (k == 3) ? 5 : (k == 4) ? 0 : 26;
			read_cycle(n, w);
			if (k == 0)
				check("strobe period", CYCLE_CLKS, int'((t_strobe - t1) / 40));
			if (n < RESULT_BITS)
			begin
				repeat (100) @(negedge mclk);
				check("held bit", w[23 - n], pin);
			end
			check("data valid", nstrobe >= VALID_STROBE, data_valid);
			push(nxt);
			w = nxt;
		end
		n = 0;
		repeat (CYCLE_CLKS)
		begin
			@(negedge mclk);
			n += (mod_clk_en === 1'h1);
		end
		check("modulator enables", CYCLE_CLKS / MOD_DIV, n);
		// Fill the queue in one burst; later cycles must drain it in order.
		@strobe_ev;
		@(negedge mclk);
		result_valid = 1'h1;
		for (int i = 0; i < FIFO_DEPTH; i++)
		begin
			fq.push_back(24'($urandom));
			result_data = fq[i];
			@(negedge mclk);
		end
		check("fifo full", 0, result_ready);
		result_valid = 1'h0;
		for (int i = 0; i <= FIFO_DEPTH; i++)
			read_cycle(26, fq[(i < FIFO_DEPTH) ? i : FIFO_DEPTH - 1]);
		host.hold(1500);
		check("sync too early", 0, mod_reset);
		host.hold(6 * CYCLE_CLKS - 1500);
		check("sync modulator reset", 1, mod_reset);
		check("sync pin high", 1, pin);
		host.drop();
		wake_window(SYNC_START_CLKS);
		check("sync released", 0, mod_reset);
		check("sync data valid", 0, data_valid);
		host.hold(7600);
		check("power down early", 0, power_down);
		host.hold(22 * CYCLE_CLKS - 7600);
		check("power down", 1, power_down);
		host.drop();
		wake_window(WAKE_START_CLKS);
		check("woken", 0, power_down);
		tally_and_finish();
	end
	initial
	begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		$display("Error watchdog expected done seen timeout");
		tally_and_finish();
	end
endmodule
